/* verilog/exec_defines.svh */
// widths, reset values and timing counts for the literal return and rotate unit
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define DATA_W        8
`define ADDR_W        7
`define PC_W          15

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define W_RESET       8'h00
`define CARRY_RESET   1'h0
`define PC_RESET      15'h0000
`define ADDR_RESET    7'h00

// ---------------------------------------------------------------
// timing counts in instruction cycles
// ---------------------------------------------------------------
`define RETURN_CYCLES 2
`define ROTATE_CYCLES 1

`endif

/* verilog/exec_pkg.sv */
// types shared by the literal return and rotate execution unit
package exec_pkg;
`include "exec_defines.svh"

   // ------------------------------------------------------------
   // opcodes and states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_RETURN_WITH_LITERAL       = 2'b01,
      OP_ROTATE_LEFT_THROUGH_CARRY = 2'b10
   } op_type;

   typedef enum logic [1:0] {
      ST_EXEC    = 2'b01,
      ST_REFETCH = 2'b10
   } state_type;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic                 valid;
      op_type               op;
      logic [`DATA_W-1:0]   literal;
      logic [`ADDR_W-1:0]   addr;
      logic                 dest;
      logic [`DATA_W-1:0]   file_data;
   } instr_type;

   typedef struct packed {
      logic                 valid;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   data;
   } file_write_type;

   typedef struct packed {
      logic                 valid;
      logic [`PC_W-1:0]     target;
   } pc_load_type;

endpackage : exec_pkg

/* verilog/rotate_unit.sv */
// rotate left through carry, purely combinational
`timescale 1ns/1ns
`include "exec_defines.svh"
module rotate_unit
   import exec_pkg::*;
(
   input  wire logic [`DATA_W-1:0] value_in,
   input  wire logic               carry_in,
   output logic      [`DATA_W-1:0] value_out,
   output logic                    carry_out
);

   // old carry enters bit 0, old top bit leaves as carry
   always_comb begin
      value_out = {value_in[`DATA_W-2:0], carry_in};
      carry_out = value_in[`DATA_W-1];
   end

endmodule : rotate_unit

/* verilog/literal_return_and_rotate_exec.sv */
// execution of return with literal and rotate left through carry
//
// Functional notes
// - return with literal writes its 8-bit literal into the working register.
// - return with literal pops the stack and loads the PC with the top entry.
// - return with literal is one word and takes two cycles for the refetch.
// - rotate left shifts the register left, old carry to bit 0, bit 7 to carry.
// - rotate left writes the working register if dest is 0, else the register.
`timescale 1ns/1ns
`include "exec_defines.svh"
module literal_return_and_rotate_exec
   import exec_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire instr_type           instr,
   input  wire logic [`PC_W-1:0]    stack_top_entry,
   output logic                     ready,
   output logic      [`DATA_W-1:0]  w,
   output logic                     carry,
   output pc_load_type              pc_load,
   output logic                     stack_pop,
   output file_write_type           file_write
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   state_type          state_r,      state_nxt;
   logic               ready_r,      ready_nxt;
   logic [`DATA_W-1:0] w_r,          w_nxt;
   logic               carry_r,      carry_nxt;
   pc_load_type        pc_load_r,    pc_load_nxt;
   logic               stack_pop_r,  stack_pop_nxt;
   file_write_type     file_write_r, file_write_nxt;
   logic [`DATA_W-1:0] rot_value;
   logic               rot_carry;
   logic               take;

   // instruction is accepted only while not refetching
   assign take = instr.valid && ready_r;

   // ------------------------------------------------------------
   // opcode decode, shared by the checks below
   // ------------------------------------------------------------
   function automatic logic is_return(input op_type op);
      return op == OP_RETURN_WITH_LITERAL;
   endfunction : is_return

   function automatic logic is_rotate(input op_type op);
      return op == OP_ROTATE_LEFT_THROUGH_CARRY;
   endfunction : is_rotate

   // anything else is an encoding the unit leaves alone
   function automatic logic is_known(input op_type op);
      return is_return(op) || is_rotate(op);
   endfunction : is_known

   // ------------------------------------------------------------
   // rotate datapath
   // ------------------------------------------------------------
   rotate_unit rotate_unit_inst (
      .value_in  (instr.file_data),
      .carry_in  (carry_r),
      .value_out (rot_value),
      .carry_out (rot_carry)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_nxt      = state_r;
      w_nxt          = w_r;
      carry_nxt      = carry_r;
      pc_load_nxt    = '0;
      stack_pop_nxt  = 1'b0;
      file_write_nxt = '0;
      case (state_r)
         ST_EXEC: begin
            if (take) begin
               case (instr.op)
                  OP_RETURN_WITH_LITERAL: begin
                     w_nxt              = instr.literal;
                     pc_load_nxt.valid  = 1'b1;
                     pc_load_nxt.target = stack_top_entry;
                     stack_pop_nxt      = 1'b1;
                     state_nxt          = ST_REFETCH;
                  end
                  OP_ROTATE_LEFT_THROUGH_CARRY: begin
                     carry_nxt = rot_carry;
                     if (!instr.dest) begin
                        w_nxt = rot_value;
                     end else begin
                        file_write_nxt.valid = 1'b1;
                        file_write_nxt.addr  = instr.addr;
                        file_write_nxt.data  = rot_value;
                     end
                  end
                  default: begin
                     state_nxt = ST_EXEC;                     // unknown op ignored
                  end
               endcase
            end
         end
         ST_REFETCH: begin
            state_nxt = ST_EXEC;
         end
         default: begin
            state_nxt = ST_EXEC;
         end
      endcase
      ready_nxt = (state_nxt == ST_EXEC);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r      <= ST_EXEC;
         ready_r      <= 1'b1;
         w_r          <= `W_RESET;
         carry_r      <= `CARRY_RESET;
         pc_load_r    <= '0;
         stack_pop_r  <= 1'b0;
         file_write_r <= '0;
      end else begin
         state_r      <= state_nxt;
         ready_r      <= ready_nxt;
         w_r          <= w_nxt;
         carry_r      <= carry_nxt;
         pc_load_r    <= pc_load_nxt;
         stack_pop_r  <= stack_pop_nxt;
         file_write_r <= file_write_nxt;
      end
   end

   // outputs straight from flops
   assign ready      = ready_r;
   assign w          = w_r;
   assign carry      = carry_r;
   assign pc_load    = pc_load_r;
   assign stack_pop  = stack_pop_r;
   assign file_write = file_write_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // checks run on the core clock and sleep while reset is low
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence seq_ret_issue;
      take && is_return(instr.op);
   endsequence

   sequence seq_rot_issue;
      take && is_rotate(instr.op);
   endsequence

   sequence seq_refetch;
      !ready_r ##1 ready_r;
   endsequence

   a_literal_to_w: assert property (
      seq_ret_issue |=> w_r == $past(instr.literal))
      else $error("literal not loaded into w");

   a_pop_loads_pc: assert property (
      seq_ret_issue |=> stack_pop_r && pc_load_r.valid &&
                        pc_load_r.target == $past(stack_top_entry))
      else $error("return did not pop and load pc");

   a_return_two_cycles: assert property (
      seq_ret_issue |=> seq_refetch)
      else $error("return did not take two cycles");

   a_rotate_value: assert property (
      seq_rot_issue |=>
         ((file_write_r.valid ? file_write_r.data : w_r) ==
          {$past(instr.file_data[`DATA_W-2:0]), $past(carry_r)}) &&
         carry_r == $past(instr.file_data[`DATA_W-1]))
      else $error("rotate result or carry wrong");

   a_dest_to_w: assert property (
      seq_rot_issue ##0 !instr.dest |=> !file_write_r.valid)
      else $error("rotate to w wrote register");

   a_dest_to_file: assert property (
      seq_rot_issue ##0 instr.dest |=> file_write_r.valid &&
         file_write_r.addr == $past(instr.addr) && $stable(w_r))
      else $error("rotate to register misdirected");

   a_rotate_one_cycle: assert property (
      seq_rot_issue |=> ready_r && !stack_pop_r && !pc_load_r.valid)
      else $error("rotate not single cycle");

   a_carry_only_rotate: assert property (
      !(take && is_rotate(instr.op)) |=> $stable(carry_r))
      else $error("carry changed outside rotate");

   a_unknown_ignored: assert property (
      take && !is_known(instr.op) |=> ready_r && $stable(w_r) &&
         $stable(carry_r) && !stack_pop_r && !pc_load_r.valid &&
         !file_write_r.valid)
      else $error("unknown op changed the outputs");

   a_refetch_ignored: assert property (
      !ready_r |=> ready_r && $stable(w_r) && $stable(carry_r) &&
         !stack_pop_r && !file_write_r.valid)
      else $error("request in the refetch slot was acted on");

   a_pop_with_pc: assert property (
      stack_pop_r == pc_load_r.valid)
      else $error("stack pop and pc load out of step");

   a_pop_single: assert property (
      stack_pop_r |=> !stack_pop_r)
      else $error("stack popped twice in a row");

endmodule : literal_return_and_rotate_exec

/* verif/test_literal_return_and_rotate_exec.sv */
// self-checking bench for the literal return and rotate execution unit
`timescale 1ns/1ns
`include "exec_defines.svh"
module test_literal_return_and_rotate_exec
   import exec_pkg::*;
();
   logic                clk;
   logic                reset_n;
   instr_type           instr;
   logic [`PC_W-1:0]    stack_top_entry;
   logic                ready;
   logic [`DATA_W-1:0]  w;
   logic                carry;
   pc_load_type         pc_load;
   logic                stack_pop;
   file_write_type      file_write;
   int                  errors;
   int                  samples_checked;

   literal_return_and_rotate_exec literal_return_and_rotate_exec_inst (
      .clk             (clk),
      .reset_n         (reset_n),
      .instr           (instr),
      .stack_top_entry (stack_top_entry),
      .ready           (ready),
      .w               (w),
      .carry           (carry),
      .pc_load         (pc_load),
      .stack_pop       (stack_pop),
      .file_write      (file_write)
   );

   // 125 MHz clock
   always #4 clk = ~clk;

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check_val(input string name, input logic [15:0] seen,
                            input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check_val

   task automatic give_verdict();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   // present one instruction until the edge that takes it, then settle
   task automatic send(input op_type op, input logic [7:0] lit,
                       input logic [6:0] addr, input logic dest,
                       input logic [7:0] fd);
      int n;
      n = 0;
      while (ready !== 1'b1) begin
         n++;
         if (n > 10) begin
            errors++;
            give_verdict();
         end
         @(posedge clk);
         #1;
      end
      instr = '{1'b1, op, lit, addr, dest, fd};
      @(posedge clk);
      #1;
   endtask : send

   // drop valid and let one edge pass
   task automatic idle();
      instr.valid = 1'b0;
      @(posedge clk);
      #1;
   endtask : idle

   // quiet outputs: no pulses, ready high
   task automatic check_quiet();
      check_val("pc_valid", 16'(pc_load.valid), 16'h0000);
      check_val("stack_pop", 16'(stack_pop), 16'h0000);
      check_val("fw_valid", 16'(file_write.valid), 16'h0000);
      check_val("ready", 16'(ready), 16'h0001);
   endtask : check_quiet

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // rotate to w then rotate back to the register, back to back
   task automatic rotate_pair();
      send(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 7'h05, 1'b0, 8'hE6);
      check_val("w", 16'(w), 16'h00CC);
      check_val("carry", 16'(carry), 16'h0001);
      check_val("fw_valid", 16'(file_write.valid), 16'h0000);
      check_val("ready", 16'(ready), 16'h0001);
      check_val("pc_valid", 16'(pc_load.valid), 16'h0000);
      send(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 7'h7F, 1'b1, 8'h35);
      check_val("fw_valid", 16'(file_write.valid), 16'h0001);
      check_val("fw_addr", 16'(file_write.addr), 16'h007F);
      check_val("fw_data", 16'(file_write.data), 16'h006B);
      check_val("carry", 16'(carry), 16'h0000);
      check_val("w", 16'(w), 16'h00CC);
      check_val("stack_pop", 16'(stack_pop), 16'h0000);
      idle();
      check_quiet();
   endtask : rotate_pair

   // return with literal, a request in the refetch slot must be ignored
   task automatic return_case(input logic [7:0] lit, input logic c_old);
      stack_top_entry = 15'h5A3C;
      send(OP_RETURN_WITH_LITERAL, lit, 7'h00, 1'b0, 8'h00);
      stack_top_entry = 15'h0001;
      check_val("w", 16'(w), {8'h00, lit});
      check_val("pc_valid", 16'(pc_load.valid), 16'h0001);
      check_val("pc_target", 16'(pc_load.target), 16'h5A3C);
      check_val("stack_pop", 16'(stack_pop), 16'h0001);
      check_val("ready", 16'(ready), 16'h0000);
      check_val("carry", 16'(carry), {15'h0000, c_old});
      instr = '{1'b1, OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 7'h11, 1'b1, 8'hFF};
      @(posedge clk);
      #1;
      check_quiet();
      check_val("w", 16'(w), {8'h00, lit});
      check_val("carry", 16'(carry), {15'h0000, c_old});
      idle();
   endtask : return_case

   // rotate of a lone top bit: zero result, carry set for the next return
   task automatic rotate_top_bit();
      send(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 7'h00, 1'b0, 8'h80);
      check_val("w", 16'(w), 16'h0000);
      check_val("carry", 16'(carry), 16'h0001);
      idle();
   endtask : rotate_top_bit

   // an unknown encoding is taken and leaves every output alone
   task automatic unknown_op();
      send(op_type'(2'b11), 8'h5A, 7'h22, 1'b1, 8'h01);
      check_quiet();
      check_val("w", 16'(w), 16'h00FF);
      check_val("carry", 16'(carry), 16'h0001);
      idle();
   endtask : unknown_op

   // reset in the refetch slot, then a clean return after release
   task automatic reset_midrun();
      stack_top_entry = 15'h1234;
      send(OP_RETURN_WITH_LITERAL, 8'hA5, 7'h00, 1'b0, 8'h00);
      reset_n = 1'b0;
      @(posedge clk);
      #1;
      check_val("w", 16'(w), 16'h0000);
      check_val("carry", 16'(carry), 16'h0000);
      check_quiet();
      reset_n = 1'b1;
      return_case(8'h3C, 1'b0);
   endtask : reset_midrun

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      instr = '0;
      stack_top_entry = 15'h0000;
      errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      #1;
      reset_n = 1'b1;
      check_val("w", 16'(w), 16'h0000);
      check_val("carry", 16'(carry), 16'h0000);
      check_quiet();
      rotate_pair();
      return_case(8'h07, 1'b0);
      rotate_top_bit();
      return_case(8'hFF, 1'b1);
      unknown_op();
      reset_midrun();
      give_verdict();
   end
endmodule : test_literal_return_and_rotate_exec
